/* framer_consts.svh */
`ifndef FRAMER_CONSTS_SVH
`define FRAMER_CONSTS_SVH
`define HDR_START_BYTE 8'h81
`define MAX_PAYLOAD_LEN 8'h80
`define HDR_OVERHEAD 9'h007
`define BUF_BYTES 9'h100
`define BCAST_ADDR_BYTE 8'hFF
`define RETRY_DEFAULT 8'h04
`define RETRY_MIN 8'h02
`define CHAN_MIN 8'h10
`define CHAN_MAX 8'h2F
`define NETID_MAX 9'h100
`define RF_RATE_BPS 76800
`define HOST_BAUD_DEFAULT 57600
`define CLK_HZ 200000000
`define RF_BIT_CYCLES (`CLK_HZ / `RF_RATE_BPS)
`endif

/* framer_pkg.sv */
package framer_pkg;
    typedef enum logic [6:0] {
        ST_HUNT = 7'b000_0001,
        ST_LEN = 7'b000_0010,
        ST_SESS = 7'b000_0100,
        ST_TRY = 7'b000_1000,
        ST_ADDR = 7'b001_0000,
        ST_DATA = 7'b010_0000,
        ST_RAW = 7'b100_0000
    } frame_state_e;
    typedef enum logic [1:0] {
        DLV_ADDRESSED = 2'b00,
        DLV_AUTO = 2'b01,
        DLV_BROADCAST = 2'b10
    } delivery_e;
endpackage : framer_pkg

/* serial_radio_packet_framer.sv */
// Function
// - Bad header: send string raw, rehunt
// - Header bytes held in buffer, count toward 256
// - Address FFFFFF sends framed packet as broadcast
// - Addressed: retry to maximum, then discard
// - Broadcast: send configured attempt count, no fewer than 2
// - Random back-off wait after collision
// - Receive accepts channel only within 16 to 47; tx_channel_o passes any value
// - Talk only with matching channel and id
// - Encrypt packets with 56-bit key when enabled
// - Broadcast mode addresses all network units
// - Auto destination latches first sender address
// - Addressed mode sends to destination, receives destination and broadcasts
// - Ignore-broadcast drops received broadcasts
// - Request-to-send option enables flow control
// - Send to host only while rts low
// - Parity enabled selects 9-bit serial mode
// - Full duplex shares channel both directions
// - Modem mode drives handshake lines, not 485
// - Radio rate fixed at 76.8 kbps
// - Host framing overrides delivery mode setting
`timescale 1ns/100ps
`default_nettype none
`include "framer_consts.svh"
module serial_radio_packet_framer #(
    parameter int BUF_DEPTH = 256
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic host_framed_transmit_i,
    input wire framer_pkg::delivery_e delivery_mode_i,
    input wire logic [23:0] dest_addr_cfg_i,
    input wire logic [7:0] max_retries_i,
    input wire logic [7:0] bcast_attempts_i,
    input wire logic [7:0] backoff_spread_i,
    input wire logic [7:0] channel_cfg_i,
    input wire logic [8:0] network_password_id_i,
    input wire logic encrypt_en_i,
    input wire logic [55:0] encrypt_key_i,
    input wire logic ignore_bcast_i,
    input wire logic rts_enable_i,
    input wire logic parity_en_i,
    input wire logic parity_odd_i,
    input wire logic full_duplex_i,
    input wire logic modem_mode_i,
    input wire logic rs485_sel_i,
    input wire logic host_valid_i,
    input wire logic [7:0] host_byte_i,
    output logic host_ready_o,
    output logic tx_valid_o,
    output logic [7:0] tx_byte_o,
    output logic tx_last_o,
    output logic [23:0] tx_dest_o,
    output logic tx_bcast_o,
    output logic [7:0] tx_attempts_o,
    output logic tx_retry_mode_o,
    output logic tx_encrypt_o,
    output logic [55:0] tx_key_o,
    output logic [7:0] tx_channel_o,
    output logic [8:0] tx_netid_o,
    output logic channel_ok_o,
    output logic [15:0] rf_bit_cycles_o,
    output logic full_duplex_o,
    input wire logic tx_ack_i,
    input wire logic tx_nack_i,
    input wire logic tx_collision_i,
    output logic tx_resend_o,
    output logic tx_done_o,
    output logic tx_discard_o,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic [23:0] rx_src_i,
    input wire logic rx_is_bcast_i,
    input wire logic [7:0] rx_channel_i,
    input wire logic [8:0] rx_netid_i,
    output logic host_out_valid_o,
    output logic [7:0] host_out_byte_o,
    input wire logic host_rts_i,
    output logic serial_9bit_o,
    output logic serial_parity_odd_o,
    output logic dcd_o,
    output logic dsr_o,
    output logic ri_o,
    input wire logic dtr_i
);
    import framer_pkg::*;

    // ==========================================
    // Pin synchronisers
    // ==========================================
    logic [2:0] rts_sync_ff;
    logic [2:0] dtr_sync_ff;
    logic rts_level_ff;
    logic dtr_level_ff;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rts_sync_ff <= 3'h7;
            dtr_sync_ff <= 3'h0;
            rts_level_ff <= 1'b1;
            dtr_level_ff <= 1'b0;
        end else if (clk_en_i) begin
            rts_sync_ff <= {rts_sync_ff[1:0], host_rts_i};
            dtr_sync_ff <= {dtr_sync_ff[1:0], dtr_i};
            if (rts_sync_ff[1] == rts_sync_ff[2]) begin
                rts_level_ff <= rts_sync_ff[2];
            end
            if (dtr_sync_ff[1] == dtr_sync_ff[2]) begin
                dtr_level_ff <= dtr_sync_ff[2];
            end
        end
    end

    // ==========================================
    // Static configuration
    // ==========================================
    logic chan_ok;
    assign chan_ok = (channel_cfg_i >= `CHAN_MIN) && (channel_cfg_i <= `CHAN_MAX);
    assign channel_ok_o = chan_ok;
    assign tx_channel_o = channel_cfg_i;
    assign tx_netid_o = network_password_id_i;
    assign tx_encrypt_o = encrypt_en_i;
    assign tx_key_o = encrypt_en_i ? encrypt_key_i : 56'h0;
    assign rf_bit_cycles_o = 16'(`RF_BIT_CYCLES);
    assign full_duplex_o = full_duplex_i;
    assign serial_9bit_o = parity_en_i;
    assign serial_parity_odd_o = parity_en_i & parity_odd_i;
    // Modem lines only in modem mode; the 485 port has no such wires
    logic modem_on;
    assign modem_on = modem_mode_i & ~rs485_sel_i;

    // ==========================================
    // Host framer
    // ==========================================
    frame_state_e state_ff;
    logic [7:0] len_ff;
    logic [7:0] cnt_ff;
    logic [7:0] try_ff;
    logic [1:0] addr_idx_ff;
    logic [23:0] addr_ff;
    logic [8:0] used_ff;
    logic busy_ff;
    logic take;
    logic bad_len;
    assign bad_len = (host_byte_i == 8'h00) || (host_byte_i > `MAX_PAYLOAD_LEN);
    // Buffer holds header plus payload until the packet leaves
    assign host_ready_o = ~busy_ff && (used_ff < 9'(BUF_DEPTH));
    assign take = clk_en_i & host_valid_i & host_ready_o;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff <= ST_HUNT;
            len_ff <= 8'h00;
            cnt_ff <= 8'h00;
            try_ff <= 8'h00;
            addr_idx_ff <= 2'h0;
            addr_ff <= 24'h00_0000;
        end else if (take) begin
            unique case (state_ff)
                ST_HUNT: begin
                    cnt_ff <= 8'h00;
                    // Any other byte is a one-byte packet of its own, so the hunt goes on
                    if (host_framed_transmit_i && host_byte_i == `HDR_START_BYTE) begin
                        state_ff <= ST_LEN;
                    end
                end
                ST_LEN: begin
                    len_ff <= host_byte_i;
                    state_ff <= bad_len ? ST_RAW : ST_SESS;
                    cnt_ff <= 8'h00;
                end
                ST_SESS: state_ff <= ST_TRY;
                ST_TRY: begin
                    try_ff <= host_byte_i;
                    addr_idx_ff <= 2'h0;
                    state_ff <= ST_ADDR;
                end
                ST_ADDR: begin
                    addr_ff <= {addr_ff[15:0], host_byte_i};
                    addr_idx_ff <= addr_idx_ff + 2'h1;
                    cnt_ff <= 8'h00;
                    if (addr_idx_ff == 2'h2) begin
                        state_ff <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    cnt_ff <= cnt_ff + 8'h01;
                    if (cnt_ff + 8'h01 == len_ff) begin
                        state_ff <= ST_HUNT;
                    end
                end
                ST_RAW: begin
                    cnt_ff <= cnt_ff + 8'h01;
                    if (cnt_ff + 8'h01 >= `MAX_PAYLOAD_LEN) begin
                        state_ff <= ST_HUNT;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // Stream to radio and buffer accounting
    // ==========================================
    logic pass_byte;
    logic last_byte;
    assign pass_byte = (state_ff == ST_DATA) || (state_ff == ST_RAW)
        || (state_ff == ST_HUNT && !(host_framed_transmit_i && host_byte_i == `HDR_START_BYTE));
    assign last_byte = (state_ff == ST_DATA && cnt_ff + 8'h01 == len_ff)
        || (state_ff == ST_RAW && cnt_ff + 8'h01 >= `MAX_PAYLOAD_LEN)
        || (state_ff == ST_HUNT);
    logic framed_pkt;
    assign framed_pkt = (state_ff == ST_DATA);
    logic pkt_bcast;
    // Host framing wins over the configured delivery mode
    assign pkt_bcast = framed_pkt ? (addr_ff == {3{`BCAST_ADDR_BYTE}})
        : (delivery_mode_i == DLV_BROADCAST);
    logic [23:0] auto_dest_ff;
    logic auto_locked_ff;
    logic [7:0] pkt_tries;
    assign pkt_tries = framed_pkt ? try_ff
        : (pkt_bcast ? bcast_attempts_i : max_retries_i);

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_valid_o <= 1'b0;
            tx_byte_o <= 8'h00;
            tx_last_o <= 1'b0;
            tx_dest_o <= 24'h00_0000;
            tx_bcast_o <= 1'b0;
            tx_attempts_o <= `RETRY_DEFAULT;
            tx_retry_mode_o <= 1'b0;
        end else if (clk_en_i) begin
            tx_valid_o <= take & pass_byte;
            tx_last_o <= take & pass_byte & last_byte;
            if (take & pass_byte) begin
                tx_byte_o <= host_byte_i;
                tx_bcast_o <= pkt_bcast;
                tx_retry_mode_o <= ~pkt_bcast;
                tx_attempts_o <= (pkt_tries < `RETRY_MIN) ? `RETRY_MIN : pkt_tries;
                if (pkt_bcast) begin
                    tx_dest_o <= {3{`BCAST_ADDR_BYTE}};
                end else if (framed_pkt) begin
                    tx_dest_o <= addr_ff;
                end else if (delivery_mode_i == DLV_AUTO) begin
                    tx_dest_o <= auto_dest_ff;
                end else begin
                    tx_dest_o <= dest_addr_cfg_i;
                end
            end
        end
    end

    // Whole packet but its last byte, header included, stays counted until it is done or discarded
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            used_ff <= 9'h000;
            busy_ff <= 1'b0;
        end else if (clk_en_i) begin
            if (take & pass_byte & last_byte) begin
                busy_ff <= 1'b1;
            end else if (tx_done_o | tx_discard_o) begin
                busy_ff <= 1'b0;
                used_ff <= 9'h000;
            end else if (take) begin
                used_ff <= used_ff + 9'h001;
            end
        end
    end

    // ==========================================
    // Delivery: retries, attempts, back-off
    // ==========================================
    logic [7:0] sent_ff;
    logic [7:0] backoff_ff;
    logic [15:0] lfsr_ff;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sent_ff <= 8'h00;
            backoff_ff <= 8'h00;
            lfsr_ff <= 16'hACE1;
            tx_resend_o <= 1'b0;
            tx_done_o <= 1'b0;
            tx_discard_o <= 1'b0;
        end else if (clk_en_i) begin
            lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
            tx_resend_o <= 1'b0;
            tx_done_o <= 1'b0;
            tx_discard_o <= 1'b0;
            if (!busy_ff) begin
                sent_ff <= 8'h00;
            end else if (backoff_ff != 8'h00) begin
                backoff_ff <= backoff_ff - 8'h01;
                if (backoff_ff == 8'h01) begin
                    tx_resend_o <= 1'b1;
                end
            end else if (tx_collision_i) begin
                backoff_ff <= (lfsr_ff[7:0] & backoff_spread_i) | 8'h01;
            end else if (tx_ack_i && !tx_bcast_o) begin
                tx_done_o <= 1'b1;
            end else if (tx_nack_i) begin
                sent_ff <= sent_ff + 8'h01;
                if (sent_ff + 8'h01 >= tx_attempts_o) begin
                    // Broadcast ends after its attempts; addressed is dropped
                    tx_done_o <= tx_bcast_o;
                    tx_discard_o <= ~tx_bcast_o;
                end else begin
                    tx_resend_o <= 1'b1;
                end
            end
        end
    end

    // ==========================================
    // Receive filter and host output
    // ==========================================
    logic rx_net_ok;
    logic rx_ok;
    assign rx_net_ok = chan_ok && rx_channel_i == channel_cfg_i && rx_netid_i == network_password_id_i;
    assign rx_ok = rx_net_ok && !(rx_is_bcast_i && ignore_bcast_i)
        && (rx_is_bcast_i || delivery_mode_i != DLV_ADDRESSED || rx_src_i == dest_addr_cfg_i);
    logic host_hold;
    assign host_hold = rts_enable_i & rts_level_ff;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            auto_dest_ff <= 24'h00_0000;
            auto_locked_ff <= 1'b0;
        end else if (clk_en_i && rx_valid_i && rx_net_ok && !rx_is_bcast_i && !auto_locked_ff
                && delivery_mode_i == DLV_AUTO) begin
            auto_dest_ff <= rx_src_i;
            auto_locked_ff <= 1'b1;
        end
    end

    // No receive buffer: a held byte is dropped while the host stalls
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            host_out_valid_o <= 1'b0;
            host_out_byte_o <= 8'h00;
        end else if (clk_en_i) begin
            host_out_valid_o <= rx_valid_i & rx_ok & ~host_hold;
            if (rx_valid_i & rx_ok) begin
                host_out_byte_o <= rx_byte_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dcd_o <= 1'b0;
            dsr_o <= 1'b0;
            ri_o <= 1'b0;
        end else if (clk_en_i) begin
            dcd_o <= modem_on & rx_valid_i & rx_ok;
            dsr_o <= modem_on;
            ri_o <= modem_on & dtr_level_ff & rx_valid_i & rx_ok;
        end
    end
endmodule : serial_radio_packet_framer
`default_nettype wire

/* serial_radio_packet_framer_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module framer_checker (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic host_valid_i,
    input wire logic host_ready_o,
    input wire logic tx_valid_o,
    input wire logic tx_last_o,
    input wire logic [7:0] channel_cfg_i,
    input wire logic channel_ok_o,
    input wire logic [15:0] rf_bit_cycles_o,
    input wire logic encrypt_en_i,
    input wire logic [55:0] encrypt_key_i,
    input wire logic [55:0] tx_key_o,
    input wire logic rx_valid_i,
    input wire logic rx_is_bcast_i,
    input wire logic [7:0] rx_channel_i,
    input wire logic ignore_bcast_i,
    input wire logic host_out_valid_o,
    input wire logic modem_mode_i,
    input wire logic rs485_sel_i,
    input wire logic dsr_o,
    input wire logic parity_en_i,
    input wire logic parity_odd_i,
    input wire logic serial_9bit_o,
    input wire logic serial_parity_odd_o,
    input wire logic full_duplex_i,
    input wire logic full_duplex_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);
    // ====
    // Port relations
    property p_chan; channel_ok_o == (channel_cfg_i >= 8'h10 && channel_cfg_i <= 8'h2F); endproperty
    a_chan: assert property (p_chan) else $error("channel ok flag wrong");
    property p_rate; rf_bit_cycles_o == 16'h0A2C; endproperty
    a_rate: assert property (p_rate) else $error("radio bit period wrong");
    property p_key; tx_key_o == (encrypt_en_i ? encrypt_key_i : 56'h00_0000_0000_0000); endproperty
    a_key: assert property (p_key) else $error("key output wrong");
    // A byte on the radio side must come from a host byte taken one edge before
    property p_ans; tx_valid_o |-> $past(clk_en_i) && $past(host_valid_i) && $past(host_ready_o); endproperty
    a_ans: assert property (p_ans) else $error("radio byte without host byte");
    property p_busy; tx_last_o |-> !host_ready_o; endproperty
    a_busy: assert property (p_busy) else $error("host taken while packet pending");
    property p_rxch; clk_en_i && rx_valid_i && rx_channel_i != channel_cfg_i |=> !host_out_valid_o; endproperty
    a_rxch: assert property (p_rxch) else $error("foreign channel passed");
    property p_ign; clk_en_i && rx_valid_i && rx_is_bcast_i && ignore_bcast_i |=> !host_out_valid_o; endproperty
    a_ign: assert property (p_ign) else $error("ignored broadcast passed");
    property p_dsr; clk_en_i |=> dsr_o == ($past(modem_mode_i) && !$past(rs485_sel_i)); endproperty
    a_dsr: assert property (p_dsr) else $error("modem line wrong");
    property p_par; (serial_9bit_o == parity_en_i) && (serial_parity_odd_o == (parity_en_i && parity_odd_i)); endproperty
    a_par: assert property (p_par) else $error("serial parity mode wrong");
    property p_fdx; full_duplex_o == full_duplex_i; endproperty
    a_fdx: assert property (p_fdx) else $error("full duplex output wrong");
endmodule : framer_checker
bind serial_radio_packet_framer framer_checker framer_checker_i (.sys_clk_i, .nrst_i, .clk_en_i, .host_valid_i,
    .host_ready_o, .tx_valid_o, .tx_last_o, .channel_cfg_i, .channel_ok_o, .rf_bit_cycles_o, .encrypt_en_i,
    .encrypt_key_i, .tx_key_o, .rx_valid_i, .rx_is_bcast_i, .rx_channel_i, .ignore_bcast_i, .host_out_valid_o,
    .modem_mode_i, .rs485_sel_i, .dsr_o, .parity_en_i, .parity_odd_i, .serial_9bit_o, .serial_parity_odd_o,
    .full_duplex_i, .full_duplex_o);
`default_nettype wire

/* host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ready_i,
    output logic valid_o,
    output logic [7:0] byte_o
);
    logic [7:0] q[$];
    // Bytes move on the block's clock but ignore clk_en_i, so host and device rates agree only while the enable is high
    // ====
    // Byte stream, held until taken; idle data toggles so a stale byte never reads as fresh
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            valid_o <= 1'b0;
            byte_o <= 8'h00;
        end else begin
            if (valid_o && ready_i)
                void'(q.pop_front());
            if (q.size() > 0) begin
                valid_o <= 1'b1;
                byte_o <= q[0];
            end else begin
                valid_o <= 1'b0;
                byte_o <= ~byte_o;
            end
        end
    end
    task automatic push(logic [7:0] b);
        q.push_back(b);
    endtask : push
endmodule : host_model
`default_nettype wire

/* serial_radio_packet_framer_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module serial_radio_packet_framer_tb_top;
    import framer_pkg::*;
    localparam logic [7:0] chan_sweep[4] = '{8'h0F, 8'h10, 8'h2F, 8'h30};
    logic sys_clk_i = 1'b0, nrst_i = 1'b0, host_framed_transmit_i = 1'b0, encrypt_en_i = 1'b0;
    logic ignore_bcast_i = 1'b0, rts_enable_i = 1'b0, parity_en_i = 1'b0, parity_odd_i = 1'b0;
    logic full_duplex_i = 1'b0, modem_mode_i = 1'b0, rs485_sel_i = 1'b0, dtr_i = 1'b0;
    logic rx_valid_i = 1'b0, rx_is_bcast_i = 1'b0, host_rts_i = 1'b0, clk_en_i = 1'b1;
    delivery_e delivery_mode_i = DLV_ADDRESSED;
    logic [7:0] bcast_attempts_i = 8'h04, channel_cfg_i = 8'h19, rx_channel_i = 8'h19, max_retries_i = 8'h04;
    logic [8:0] network_password_id_i = 9'h07B, rx_netid_i = 9'h07B;
    logic [23:0] rx_src_i = 24'h00_0000;
    logic [55:0] encrypt_key_i = 56'h00_0000_0000_0000;
    logic [2:0] evt = 3'h0;
    logic host_valid_i, host_ready_o, tx_valid_o, tx_last_o, tx_bcast_o, tx_resend_o, tx_done_o, tx_discard_o;
    logic host_out_valid_o, got_last;
    logic [7:0] host_byte_i, tx_byte_o, tx_attempts_o;
    logic [23:0] tx_dest_o;
    logic [8:0] txq[$];
    int error_cnt = 0, num_checks = 0, n_res = 0, n_done = 0, n_disc = 0, n_out = 0, cyc = 0;
    serial_radio_packet_framer serial_radio_packet_framer_i (
        .sys_clk_i, .nrst_i, .clk_en_i, .host_framed_transmit_i, .delivery_mode_i,
        .dest_addr_cfg_i(24'h12_3456), .max_retries_i, .bcast_attempts_i, .backoff_spread_i(8'h00),
        .channel_cfg_i, .network_password_id_i, .encrypt_en_i, .encrypt_key_i, .ignore_bcast_i, .rts_enable_i,
        .parity_en_i, .parity_odd_i, .full_duplex_i, .modem_mode_i, .rs485_sel_i, .host_valid_i, .host_byte_i,
        .host_ready_o, .tx_valid_o, .tx_byte_o, .tx_last_o, .tx_dest_o, .tx_bcast_o, .tx_attempts_o,
        .tx_retry_mode_o(), .tx_encrypt_o(), .tx_key_o(), .tx_channel_o(), .tx_netid_o(), .channel_ok_o(),
        .rf_bit_cycles_o(), .full_duplex_o(), .tx_ack_i(evt[0]), .tx_nack_i(evt[1]), .tx_collision_i(evt[2]),
        .tx_resend_o, .tx_done_o, .tx_discard_o, .rx_valid_i, .rx_byte_i(8'h6B), .rx_src_i, .rx_is_bcast_i,
        .rx_channel_i, .rx_netid_i, .host_out_valid_o, .host_out_byte_o(), .host_rts_i, .serial_9bit_o(),
        .serial_parity_odd_o(), .dcd_o(), .dsr_o(), .ri_o(), .dtr_i
    );
    host_model host_model_i (.sys_clk_i, .nrst_i, .ready_i(host_ready_o), .valid_o(host_valid_i), .byte_o(host_byte_i));
    initial begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    // ====
    // Monitor and timeout
    always @(posedge sys_clk_i) begin
        cyc++;
        if (tx_valid_o === 1'b1)
            txq.push_back({tx_last_o, tx_byte_o});
        if (tx_valid_o === 1'b1 && tx_last_o === 1'b1)
            got_last = 1'b1;
        n_res += int'(tx_resend_o === 1'b1);
        n_done += int'(tx_done_o === 1'b1);
        n_disc += int'(tx_discard_o === 1'b1);
        n_out += int'(host_out_valid_o === 1'b1);
        if (cyc == 8000) begin
            error_cnt++;
            finish_test();
        end
    end
    // ====
    // Tasks
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk
    task automatic pkt(logic [7:0] d[$], logic [7:0] tries, logic [23:0] a, bit hdr);
        txq.delete();
        got_last = 1'b0;
        n_res = 0;
        n_done = 0;
        n_disc = 0;
        if (hdr) begin
            host_model_i.push(8'h81);
            host_model_i.push(8'(d.size()));
            host_model_i.push(8'h00);
            host_model_i.push(tries);
            host_model_i.push(a[23:16]);
            host_model_i.push(a[15:8]);
            host_model_i.push(a[7:0]);
        end
        foreach (d[i]) host_model_i.push(d[i]);
        for (int k = 0; k < 400 && !got_last; k++) @(posedge sys_clk_i);
    endtask : pkt
    // Radio answers are one-cycle pulses with settle time after each
    task automatic fire(int k, int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            evt <= 3'(1 << k);
            @(posedge sys_clk_i);
            evt <= 3'h0;
            repeat (4) @(posedge sys_clk_i);
        end
    endtask : fire
    task automatic rxc(logic [23:0] src, logic bc, logic [7:0] ch, logic [8:0] id, int exp);
        repeat (5) @(posedge sys_clk_i);
        n_out = 0;
        rx_src_i <= src;
        rx_is_bcast_i <= bc;
        rx_channel_i <= ch;
        rx_netid_i <= id;
        rx_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        rx_valid_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        chk("host out", exp, n_out);
    endtask : rxc
    task automatic finish_test();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    // ====
    // Main sequence
    initial begin
        logic [7:0] raw[$];
        repeat (16) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        @(posedge sys_clk_i);
        chk("attempts rst", 8'h04, tx_attempts_o);
        foreach (chan_sweep[i]) begin
            @(posedge sys_clk_i);
            channel_cfg_i <= chan_sweep[i];
            encrypt_en_i <= i[0];
            encrypt_key_i <= {7{chan_sweep[i]}};
            parity_en_i <= i[1];
            parity_odd_i <= i[0];
            full_duplex_i <= i[1];
            modem_mode_i <= i[0];
            rs485_sel_i <= i[1];
            dtr_i <= i[0];
        end
        @(posedge sys_clk_i);
        channel_cfg_i <= 8'h19;
        modem_mode_i <= 1'b0;
        delivery_mode_i <= DLV_BROADCAST;
        host_framed_transmit_i <= 1'b1;
        bcast_attempts_i <= 8'h03;
        pkt('{8'hAA, 8'hBB}, 8'h03, 24'h12_3456, 1'b1);
        chk("pkt size", 2, txq.size());
        chk("byte0", 9'h0AA, txq[0]);
        chk("byte1", 9'h1BB, txq[1]);
        chk("dest", 24'h12_3456, tx_dest_o);
        chk("bcast", 1'b0, tx_bcast_o);
        chk("tries", 8'h03, tx_attempts_o);
        // Freeze only while the host side is idle: the host model does not see the enable
        clk_en_i <= 1'b0;
        fire(1, 1);
        chk("frozen resends", 0, n_res);
        clk_en_i <= 1'b1;
        fire(1, 3);
        chk("resends", 2, n_res);
        chk("discards", 1, n_disc);
        pkt('{8'hCC}, 8'h02, 24'hFF_FFFF, 1'b1);
        chk("bcast", 1'b1, tx_bcast_o);
        chk("tries", 8'h02, tx_attempts_o);
        fire(1, 2);
        chk("resends", 1, n_res);
        chk("dones", 1, n_done);
        host_framed_transmit_i <= 1'b0;
        pkt('{8'h5A}, 8'h00, 24'h00_0000, 1'b0);
        chk("raw byte", 9'h15A, txq[0]);
        chk("bcast", 1'b1, tx_bcast_o);
        chk("tries", 8'h03, tx_attempts_o);
        fire(1, 3);
        chk("dones", 1, n_done);
        host_framed_transmit_i <= 1'b1;
        delivery_mode_i <= DLV_ADDRESSED;
        max_retries_i <= 8'h03;
        raw = '{8'h81, 8'h00};
        for (int k = 1; k <= 128; k++) raw.push_back(8'(k));
        pkt(raw, 8'h00, 24'h00_0000, 1'b0);
        chk("raw size", 128, txq.size());
        chk("raw first", 9'h001, txq[0]);
        chk("raw last", 9'h180, txq[127]);
        chk("tries", 8'h03, tx_attempts_o);
        fire(0, 1);
        chk("dones", 1, n_done);
        host_framed_transmit_i <= 1'b0;
        delivery_mode_i <= DLV_AUTO;
        rxc(24'hAB_CDEF, 1'b0, 8'h19, 9'h07B, 1);
        pkt('{8'h77}, 8'h00, 24'h00_0000, 1'b0);
        chk("auto dest", 24'hAB_CDEF, tx_dest_o);
        fire(2, 1);
        chk("backoff resend", 1, n_res);
        fire(0, 1);
        chk("dones", 1, n_done);
        delivery_mode_i <= DLV_ADDRESSED;
        rxc(24'h12_3456, 1'b0, 8'h19, 9'h07B, 1);
        rxc(24'h12_3456, 1'b0, 8'h18, 9'h07B, 0);
        rxc(24'h12_3456, 1'b0, 8'h19, 9'h07C, 0);
        rxc(24'h65_4321, 1'b0, 8'h19, 9'h07B, 0);
        rxc(24'h65_4321, 1'b1, 8'h19, 9'h07B, 1);
        ignore_bcast_i <= 1'b1;
        rxc(24'h65_4321, 1'b1, 8'h19, 9'h07B, 0);
        rts_enable_i <= 1'b1;
        host_rts_i <= 1'b1;
        rxc(24'h12_3456, 1'b0, 8'h19, 9'h07B, 0);
        host_rts_i <= 1'b0;
        rxc(24'h12_3456, 1'b0, 8'h19, 9'h07B, 1);
        finish_test();
    end
endmodule : serial_radio_packet_framer_tb_top
`default_nettype wire
